// [core/atr_defines.svh]
// Character codes, length limits and timing counts for the responder.
// Assumes inclusion by bare name from the status and responder files of the block.
`ifndef ATR_DEFINES_SVH
`define ATR_DEFINES_SVH

// Framing, filler and marker characters, channel letter and digit bounds
`define ATR_STX 8'h02
`define ATR_ETX 8'h03
`define ATR_BLANK 8'h20
`define ATR_CR 8'h0D
`define ATR_LF 8'h0A
`define ATR_QMARK 8'h3F
`define ATR_HASH 8'h23
`define ATR_CHR_K 8'h4B
`define ATR_CHR_0 8'h30
`define ATR_CHR_9 8'h39

// Two-letter reply codes, first letter in the upper byte
`define ATR_OFFLINE_CODE 16'h4F46
`define ATR_ABSENT_CODE 16'h4E41
`define ATR_OCCUPIED_CODE 16'h4253
`define ATR_FORMAT_CODE 16'h5345
`define ATR_VALUE_CODE 16'h4446

// Least command length, one-digit and two-digit channel, STX..ETX
`define ATR_MIN_LEN 9'h00A
`define ATR_MIN_LEN2 9'h00B
// Items longer than this many digits go behind CR LF
`define ATR_SPLIT_LEN 8'h3C

// Byte positions inside a command telegram
`define ATR_POS_ADDR 8'h01
`define ATR_POS_FC0 8'h02
`define ATR_POS_FC1 8'h03
`define ATR_POS_FC2 8'h04
`define ATR_POS_FC3 8'h05
`define ATR_POS_CH0 8'h08
`define ATR_POS_CH1 8'h09

// Response start and character gap limit, 2 s at 125 MHz
`define ATR_RESP_MS 2000
`define ATR_CLK_KHZ 125000
`define ATR_RESP_CYC (`ATR_RESP_MS * `ATR_CLK_KHZ)

`endif

// [core/atr_pkg.sv]
// Types shared by the telegram responder files.
// Assumes atr_defines.svh supplies all numeric constants.
package atr_pkg;

  // Response sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ASK = 3'b001,
    S_HEAD = 3'b010,
    S_CHAN = 3'b011,
    S_CODE = 3'b100,
    S_DATA = 3'b101,
    S_ETX = 3'b110
  } atr_state_e;

  // Function code groups
  typedef enum logic [1:0] {
    CLS_CTRL = 2'b00,
    CLS_READ = 2'b01,
    CLS_WRITE = 2'b10
  } atr_class_e;

endpackage

// [core/atr_cmd_mem.sv]
// Command byte store; the application reads parameters from it.
// Assumes one clock; read data appear one enabled edge after the address.
module atr_cmd_mem import atr_pkg::*; #(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic core_clk,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);

  if (DEPTH < 16 || DEPTH > (1 << AW)) begin : g_bad_depth
    $error("atr_cmd_mem: DEPTH must be 16..2**AW");
  end

  logic [7:0] mem [DEPTH];

  // No reset: contents are only meaningful below the frame length
  always_ff @(posedge core_clk) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// [core/atr_err_status.sv]
// Error status digit: zero when clean, steps 1..9 on each change.
// Assumes err_flags come from logic on core_clk.
`include "atr_defines.svh"
module atr_err_status import atr_pkg::*; #(
  parameter int ERR_W = 8
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [ERR_W-1:0] err_flags,
  output logic [7:0] status_digit
);

  logic [ERR_W-1:0] prev_r, prev_nxt;
  logic [3:0] cnt_r, cnt_nxt;

  // Count changes of the error pattern, wrap 9 back to 1
  always_comb begin
    prev_nxt = err_flags;
    cnt_nxt = cnt_r;
    if (err_flags == '0) begin
      cnt_nxt = 4'h0;
    end else if (err_flags != prev_r) begin
      cnt_nxt = (cnt_r == 4'h9) ? 4'h1 : cnt_r + 4'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prev_r <= '0;
      cnt_r <= 4'h0;
      status_digit <= `ATR_CHR_0;
    end else if (ce) begin
      prev_r <= prev_nxt;
      cnt_r <= cnt_nxt;
      status_digit <= `ATR_CHR_0 + {4'h0, cnt_nxt};
    end
  end

  clean_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    ce && err_flags == '0 |=> status_digit == `ATR_CHR_0)
    else $error("status digit not zero with no errors");
  digit_range_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    ce && err_flags != '0 && err_flags != prev_r
    |=> status_digit >= 8'h31 && status_digit <= `ATR_CHR_9)
    else $error("status digit outside 1..9 after change");

endmodule

// [core/atr_responder.sv]
// Telegram responder: frames commands, answers with echo, status, data.
// Assumes a UART outside delivers and takes bytes on core_clk.
`include "atr_defines.svh"
module atr_responder import atr_pkg::*; #(
  parameter int DATA_BITS = 8,
  parameter int MEM_DEPTH = 64,
  parameter int MEM_AW = 6,
  parameter int ERR_W = 8,
  parameter int CNT_W = 28,
  parameter logic [CNT_W-1:0] RESP_CYC = CNT_W'(`ATR_RESP_CYC)
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic bus_mode,
  input wire logic [7:0] bus_addr,
  input wire logic remote_mode,
  input wire logic system_unit,
  input wire logic member_absent,
  input wire logic func_running,
  input wire logic [ERR_W-1:0] err_flags,
  output logic cmd_ready,
  output logic [31:0] cmd_func,
  output logic [15:0] cmd_chan,
  input wire logic [MEM_AW-1:0] par_addr,
  output logic [7:0] par_data,
  input wire logic verdict_valid,
  input wire logic fc_known,
  input wire logic [1:0] fc_class,
  input wire logic fc_soft_reset,
  input wire logic fmt_fault,
  input wire logic val_fault,
  output logic exec_start,
  input wire logic item_valid,
  input wire logic [7:0] item_data,
  input wire logic item_last,
  input wire logic [7:0] item_len,
  input wire logic item_missing,
  input wire logic item_limited,
  output logic item_ready,
  input wire logic data_end
);

  if (DATA_BITS != 7 && DATA_BITS != 8) begin : g_bad_bits
    $error("atr_responder: DATA_BITS must be 7 or 8");
  end
  if (RESP_CYC < 2) begin : g_bad_cyc
    $error("atr_responder: RESP_CYC too small");
  end

  function automatic logic is_digit(input logic [7:0] c);
    return c >= `ATR_CHR_0 && c <= `ATR_CHR_9;
  endfunction

  // Receive side state
  logic in_frame_r, in_frame_nxt;
  logic [7:0] len_r, len_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic [31:0] fc_r, fc_nxt;
  logic [7:0] ch0_r, ch0_nxt, ch1_r, ch1_nxt;
  logic ch2_r, ch2_nxt;
  logic [7:0] rx_chr;
  logic frame_done, short_cmd, addr_ok;

  // Seven-bit characters carry no eighth bit into the parser
  assign rx_chr = (DATA_BITS == 7) ? {1'b0, rx_data[6:0]} : rx_data;
  assign frame_done = rx_valid && in_frame_r && rx_chr == `ATR_ETX;
  assign short_cmd = ({1'b0, len_r} + 9'h001 < `ATR_MIN_LEN) ||
    (ch2_r && {1'b0, len_r} + 9'h001 < `ATR_MIN_LEN2);
  assign addr_ok = !bus_mode || addr_r == bus_addr;

  // Frame parser; any STX throws away a half frame
  always_comb begin
    in_frame_nxt = in_frame_r;
    len_nxt = len_r;
    addr_nxt = addr_r;
    fc_nxt = fc_r;
    ch0_nxt = ch0_r;
    ch1_nxt = ch1_r;
    ch2_nxt = ch2_r;
    if (rx_valid && rx_chr == `ATR_STX) begin
      in_frame_nxt = 1'b1;
      len_nxt = 8'h01;
      ch0_nxt = `ATR_CHR_0;
      ch1_nxt = 8'h00;
      ch2_nxt = 1'b0;
    end else if (rx_valid && in_frame_r) begin
      if (rx_chr == `ATR_ETX) begin
        in_frame_nxt = 1'b0;
      end
      if (len_r != 8'hFF) begin
        len_nxt = len_r + 8'h01;
      end
      case (len_r)
        `ATR_POS_ADDR: addr_nxt = rx_chr;
        `ATR_POS_FC0: fc_nxt[31:24] = rx_chr;
        `ATR_POS_FC1: fc_nxt[23:16] = rx_chr;
        `ATR_POS_FC2: fc_nxt[15:8] = rx_chr;
        `ATR_POS_FC3: fc_nxt[7:0] = rx_chr;
        `ATR_POS_CH0: ch0_nxt = rx_chr;
        `ATR_POS_CH1: begin
          if (is_digit(rx_chr)) begin
            ch1_nxt = rx_chr;
            ch2_nxt = 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      in_frame_r <= 1'b0;
      len_r <= 8'h00;
      addr_r <= 8'h00;
      fc_r <= 32'h0;
      ch0_r <= 8'h00;
      ch1_r <= 8'h00;
      ch2_r <= 1'b0;
    end else if (ce) begin
      in_frame_r <= in_frame_nxt;
      len_r <= len_nxt;
      addr_r <= addr_nxt;
      fc_r <= fc_nxt;
      ch0_r <= ch0_nxt;
      ch1_r <= ch1_nxt;
      ch2_r <= ch2_nxt;
    end
  end

  // Response side state
  atr_state_e st_r, st_nxt;
  logic [2:0] step_r, step_nxt;
  logic unk_r, unk_nxt, chan_r, chan_nxt;
  logic [15:0] code_r, code_nxt;
  logic [7:0] raddr_r, raddr_nxt, rch0_r, rch0_nxt, rch1_r, rch1_nxt;
  logic [31:0] rfc_r, rfc_nxt;
  logic rch2_r, rch2_nxt;
  logic [CNT_W-1:0] gap_r, gap_nxt;
  logic crlf_r, crlf_nxt, mark_r, mark_nxt, drop_r, drop_nxt;
  logic tx_valid_r, tx_valid_nxt;
  logic [7:0] tx_data_r, tx_data_nxt;
  logic exec_r, exec_nxt, cmdrdy_r, cmdrdy_nxt;
  logic can, load, expired, ctlw;
  logic [7:0] chr;
  logic [7:0] status_digit;

  assign can = !tx_valid_r || tx_ready;
  assign expired = gap_r == RESP_CYC;
  assign ctlw = fc_class != CLS_READ;

  // Sequencer: head, optional channel and code, data items, ETX
  always_comb begin
    st_nxt = st_r;
    step_nxt = step_r;
    unk_nxt = unk_r;
    chan_nxt = chan_r;
    code_nxt = code_r;
    raddr_nxt = raddr_r;
    rfc_nxt = rfc_r;
    rch0_nxt = rch0_r;
    rch1_nxt = rch1_r;
    rch2_nxt = rch2_r;
    crlf_nxt = crlf_r;
    mark_nxt = mark_r;
    drop_nxt = drop_r;
    gap_nxt = expired ? gap_r : gap_r + 1'b1;
    exec_nxt = 1'b0;
    cmdrdy_nxt = 1'b0;
    item_ready = 1'b0;
    load = 1'b0;
    chr = 8'h00;
    case (st_r)
      S_IDLE: begin
        // Only a finished frame opens a response; a frame landing
        // mid-response is dropped since the master must wait
        if (frame_done && addr_ok) begin
          raddr_nxt = addr_r;
          rfc_nxt = fc_r;
          rch0_nxt = ch0_r;
          rch1_nxt = ch1_r;
          rch2_nxt = ch2_r;
          gap_nxt = '0;
          step_nxt = 3'h0;
          chan_nxt = 1'b0;
          code_nxt = 16'h0;
          unk_nxt = short_cmd;
          cmdrdy_nxt = !short_cmd;
          st_nxt = short_cmd ? S_HEAD : S_ASK;
        end
      end
      S_ASK: begin
        if (verdict_valid) begin
          st_nxt = S_HEAD;
          if (!fc_known) begin
            unk_nxt = 1'b1;
          end else if (ctlw && !remote_mode) begin
            code_nxt = `ATR_OFFLINE_CODE;
            chan_nxt = system_unit;
          end else if (ctlw && member_absent) begin
            code_nxt = `ATR_ABSENT_CODE;
            chan_nxt = 1'b1;
          end else if (fc_class == CLS_CTRL && func_running &&
                       !fc_soft_reset) begin
            code_nxt = `ATR_OCCUPIED_CODE;
            chan_nxt = system_unit;
          end else if (fmt_fault) begin
            code_nxt = `ATR_FORMAT_CODE;
          end else if (val_fault) begin
            code_nxt = `ATR_VALUE_CODE;
          end else begin
            exec_nxt = ctlw;
          end
        end else if (expired) begin
          unk_nxt = 1'b1;
          st_nxt = S_HEAD;
        end
      end
      S_HEAD: begin
        if (can) begin
          load = 1'b1;
          step_nxt = step_r + 3'h1;
          case (step_r)
            3'h0: chr = `ATR_STX;
            3'h1: chr = raddr_r;
            3'h2: chr = unk_r ? `ATR_QMARK : rfc_r[31:24];
            3'h3: chr = unk_r ? `ATR_QMARK : rfc_r[23:16];
            3'h4: chr = unk_r ? `ATR_QMARK : rfc_r[15:8];
            3'h5: chr = unk_r ? `ATR_QMARK : rfc_r[7:0];
            3'h6: chr = `ATR_BLANK;
            default: begin
              chr = status_digit;
              step_nxt = 3'h0;
              if (unk_r) begin
                st_nxt = S_ETX;
              end else if (chan_r) begin
                st_nxt = S_CHAN;
              end else if (code_r != 16'h0) begin
                st_nxt = S_CODE;
              end else begin
                st_nxt = S_DATA;
              end
            end
          endcase
        end
      end
      S_CHAN: begin
        if (can) begin
          load = 1'b1;
          step_nxt = step_r + 3'h1;
          case (step_r)
            3'h0: chr = `ATR_BLANK;
            3'h1: chr = `ATR_CHR_K;
            3'h2: chr = rch0_r;
            default: chr = rch1_r;
          endcase
          if (step_r == 3'h3 || (step_r == 3'h2 && !rch2_r)) begin
            step_nxt = 3'h0;
            st_nxt = S_CODE;
          end
        end
      end
      S_CODE: begin
        if (can) begin
          load = 1'b1;
          step_nxt = step_r + 3'h1;
          case (step_r)
            3'h0: chr = `ATR_BLANK;
            3'h1: chr = code_r[15:8];
            default: begin
              chr = code_r[7:0];
              st_nxt = S_ETX;
            end
          endcase
        end
      end
      S_DATA: begin
        if (expired) begin
          st_nxt = S_ETX;
        end else begin
          case (step_r)
            3'h0: begin
              if (data_end) begin
                st_nxt = S_ETX;
              end else if (item_valid && can) begin
                load = 1'b1;
                crlf_nxt = item_len > `ATR_SPLIT_LEN;
                chr = crlf_nxt ? `ATR_CR : `ATR_BLANK;
                mark_nxt = item_missing || item_limited;
                drop_nxt = item_missing;
                step_nxt = crlf_nxt ? 3'h1 : 3'h2;
              end
            end
            3'h1: begin
              if (can) begin
                load = 1'b1;
                chr = `ATR_LF;
                step_nxt = 3'h2;
              end
            end
            3'h2: begin
              if (!mark_r) begin
                step_nxt = 3'h3;
              end else if (can) begin
                load = 1'b1;
                chr = `ATR_HASH;
                step_nxt = 3'h3;
              end
            end
            default: begin
              // A missing reading is swallowed behind its hash
              if (item_valid && can) begin
                item_ready = ce; // No take while frozen
                load = !drop_r;
                chr = item_data;
                if (item_last) begin
                  step_nxt = 3'h0;
                end
              end
            end
          endcase
        end
      end
      S_ETX: begin
        if (can) begin
          load = 1'b1;
          chr = `ATR_ETX;
          st_nxt = S_IDLE;
        end
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  // Output byte holds until the UART takes it
  always_comb begin
    tx_valid_nxt = tx_valid_r && !tx_ready;
    tx_data_nxt = tx_data_r;
    if (load) begin
      tx_valid_nxt = 1'b1;
      tx_data_nxt = chr;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= S_IDLE;
      step_r <= 3'h0;
      unk_r <= 1'b0;
      chan_r <= 1'b0;
      code_r <= 16'h0;
      raddr_r <= 8'h00;
      rfc_r <= 32'h0;
      rch0_r <= 8'h00;
      rch1_r <= 8'h00;
      rch2_r <= 1'b0;
      gap_r <= '0;
      crlf_r <= 1'b0;
      mark_r <= 1'b0;
      drop_r <= 1'b0;
      tx_valid_r <= 1'b0;
      tx_data_r <= 8'h00;
      exec_r <= 1'b0;
      cmdrdy_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      step_r <= step_nxt;
      unk_r <= unk_nxt;
      chan_r <= chan_nxt;
      code_r <= code_nxt;
      raddr_r <= raddr_nxt;
      rfc_r <= rfc_nxt;
      rch0_r <= rch0_nxt;
      rch1_r <= rch1_nxt;
      rch2_r <= rch2_nxt;
      gap_r <= load ? '0 : gap_nxt;
      crlf_r <= crlf_nxt;
      mark_r <= mark_nxt;
      drop_r <= drop_nxt;
      tx_valid_r <= tx_valid_nxt;
      tx_data_r <= tx_data_nxt;
      exec_r <= exec_nxt;
      cmdrdy_r <= cmdrdy_nxt;
    end
  end

  assign tx_valid = tx_valid_r;
  assign tx_data = tx_data_r;
  assign exec_start = exec_r;
  assign cmd_ready = cmdrdy_r;
  assign cmd_func = rfc_r;
  assign cmd_chan = {rch0_r, rch1_r};

  // Frame bytes kept only while idle, so parameters stay put
  atr_cmd_mem #(.DEPTH(MEM_DEPTH), .AW(MEM_AW)) u_mem (
    .core_clk(core_clk),
    .ce(ce),
    // STX lands whenever idle, even after an overlong frame
    .wr_en(rx_valid && st_r == S_IDLE &&
           (rx_chr == `ATR_STX || (in_frame_r && len_r < MEM_DEPTH))),
    .wr_addr(rx_chr == `ATR_STX ? '0 : len_r[MEM_AW-1:0]),
    .wr_data(rx_chr),
    .rd_addr(par_addr),
    .rd_data(par_data)
  );

  atr_err_status #(.ERR_W(ERR_W)) u_err (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .err_flags(err_flags),
    .status_digit(status_digit)
  );

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  stx_restart_a: assert property (ce && rx_valid && rx_chr == `ATR_STX
    |=> in_frame_r && len_r == 8'h01)
    else $error("STX did not restart the frame");
  addr_silence_a: assert property (ce && st_r == S_IDLE && frame_done &&
    bus_mode && addr_r != bus_addr |=> st_r == S_IDLE)
    else $error("answered a foreign bus address");
  fc_echo_a: assert property (ce && st_r == S_HEAD && step_r == 3'h2 &&
    can && !unk_r |=> tx_data_r == rfc_r[31:24])
    else $error("function echo wrong");
  qmark_echo_a: assert property (ce && st_r == S_HEAD && step_r == 3'h5 &&
    can && unk_r |=> tx_data_r == `ATR_QMARK)
    else $error("question mark echo missing");
  crlf_split_a: assert property (ce && st_r == S_DATA && step_r == 3'h0 &&
    load && item_len > `ATR_SPLIT_LEN
    |=> tx_data_r == `ATR_CR ##1
    (!$past(ce && can && !expired) || tx_data_r == `ATR_LF))
    else $error("long item not split by CR LF");
  status_pos_a: assert property (ce && st_r == S_HEAD && step_r == 3'h7 &&
    can |=> tx_data_r == $past(status_digit))
    else $error("status digit out of place");
  busy_reply_a: assert property (ce && st_r == S_ASK && verdict_valid &&
    fc_known && fc_class == CLS_CTRL && remote_mode && !member_absent &&
    func_running && !fc_soft_reset
    |=> code_r == `ATR_OCCUPIED_CODE && !exec_start)
    else $error("busy command not refused");
  etx_last_a: assert property (ce && st_r == S_ETX && can
    |=> tx_data_r == `ATR_ETX && st_r == S_IDLE)
    else $error("telegram not closed by ETX");
  slave_only_a: assert property ($rose(tx_valid_r)
    |-> $past(st_r) != S_IDLE)
    else $error("unsolicited character sent");
  gap_bound_a: assert property (gap_r <= RESP_CYC)
    else $error("gap counter past limit");

  short_cmd_c: cover property (st_r == S_IDLE && frame_done && short_cmd);
  busy_c: cover property (code_r == `ATR_OCCUPIED_CODE && st_r == S_CODE);
  split_c: cover property (st_r == S_DATA && step_r == 3'h1 && load);
  hash_c: cover property (st_r == S_DATA && mark_r && drop_r && load);

endmodule

// [verification/atr_master_model.sv]
// Master model: sends command bytes, takes answer bytes with stalls.
// Assumes the responder's clock; it moves rx_valid, rx_data and tx_ready 1 ns after edges.
module atr_master_model (
  input wire logic core_clk,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic got_valid,
  output logic [7:0] got_byte,
  output logic waiting
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    waiting = 1'b0;
  end

  // One telegram; a gap of at least one cycle keeps the pulses apart
  task automatic send(input string s, input bit answer);
    int i;
    waiting = answer;
    for (i = 0; i < s.len(); i++) begin
      rx_valid = 1'b1;
      rx_data = s[i];
      @(posedge core_clk);
      #1;
      rx_valid = 1'b0;
      rx_data = ~rx_data; // Stale byte must not look valid
      if (i + 1 < s.len()) repeat ($urandom_range(2, 1)) begin
        @(posedge core_clk);
        #1;
      end
    end
  endtask

  // Take bytes; random stalls stretch the answer without failing it
  always @(posedge core_clk) begin
    got_valid <= tx_valid && tx_ready;
    got_byte <= tx_data;
    if (tx_valid && tx_ready && tx_data == 8'h03)
      waiting <= 1'b0;
    #1;
    tx_ready = $urandom_range(3, 0) != 0;
  end
endmodule

// [verification/tb_analyzer_telegram_responder.sv]
// Bench for the telegram responder, master model on the byte link.
// Assumes one 125 MHz clock; verdicts and items come from here.
module tb_analyzer_telegram_responder;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, sys_rst = 1'b1;
  logic rx_valid, tx_valid, tx_ready, cmd_ready, exec_start, item_ready;
  logic got_valid, waiting, bus_mode = 1'b0, remote_mode = 1'b1;
  logic [7:0] rx_data, tx_data, got_byte, par_data, bus_addr = 8'h41;
  logic [31:0] cmd_func;
  logic [15:0] cmd_chan;
  logic [5:0] par_addr = 6'h00;
  logic [7:0] err_flags = 8'h00, item_len = 8'h03, item_data = 8'h31;
  logic system_unit = 1'b0, member_absent = 1'b0, func_running = 1'b0;
  logic verdict_valid = 1'b0, fc_known = 1'b0, fc_soft_reset = 1'b0;
  logic fmt_fault = 1'b0, val_fault = 1'b0, data_end = 1'b1;
  logic item_valid = 1'b0, item_last = 1'b0;
  logic item_missing = 1'b0, item_limited = 1'b0;
  logic [1:0] fc_class = 2'h0;
  int err_total = 0, cmp_count = 0, ex_seen = 0, ex_want = 0, idx;
  bit tk;
  byte exp_q[$];
  string S = "\002", E = "\003", sep, body;

  // 8 ns period
  always #4 core_clk = ~core_clk;

  atr_responder #(.RESP_CYC(28'h00000C8)) dut (.core_clk, .sys_rst,
    .ce(1'b1), .rx_valid, .rx_data, .tx_valid, .tx_data, .tx_ready,
    .bus_mode, .bus_addr, .remote_mode, .system_unit, .member_absent,
    .func_running, .err_flags, .cmd_ready, .cmd_func, .cmd_chan,
    .par_addr, .par_data, .verdict_valid, .fc_known, .fc_class,
    .fc_soft_reset, .fmt_fault, .val_fault, .exec_start, .item_valid,
    .item_data, .item_last, .item_len, .item_missing, .item_limited,
    .item_ready, .data_end);

  atr_master_model m (.core_clk, .tx_valid, .tx_data, .tx_ready,
    .rx_valid, .rx_data, .got_valid, .got_byte, .waiting);

  task automatic chk(input bit ok, input string what);
    cmp_count++;
    if (!ok) begin
      err_total++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Note the answer, send, give the verdict {exec,known,class,soft,fmt,val}
  task automatic run(input string cmd, input bit [6:0] v, input string ans,
                     input bit ask);
    int n;
    for (n = 0; n < ans.len(); n++) exp_q.push_back(ans[n]);
    par_addr = 6'($urandom_range(8, 0));
    m.send(cmd, ans.len() != 0);
    if (ask) begin
      for (n = 0; n < 60 && cmd_ready !== 1'b1; n++) begin
        @(posedge core_clk);
        #1;
      end
      chk(n < 60, "no cmd_ready");
      chk(cmd_func === {cmd[2], cmd[3], cmd[4], cmd[5]}, "func");
      chk(cmd_chan === {cmd[8], cmd.len() > 10 ? cmd[9] : 8'h00}, "chan");
      chk(par_data === cmd[par_addr], "stored byte");
      {fc_known, fc_class, fc_soft_reset, fmt_fault, val_fault} = v[5:0];
      verdict_valid = 1'b1;
      ex_want += v[6];
      @(posedge core_clk);
      #1;
      verdict_valid = 1'b0;
    end
    // Silence is judged over more than the verdict time limit
    for (n = 0; n < 3000 && (waiting || n < 300); n++) @(posedge core_clk);
    #1;
    chk(exp_q.size() == 0 && ex_seen == ex_want, "answer or start");
  endtask

  // Compare each taken byte with the oldest note; count starts
  always @(posedge core_clk) begin
    if (exec_start === 1'b1) ex_seen++;
    if (got_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(1'b0, "byte unasked");
      else chk(got_byte === exp_q.pop_front(), "wrong byte");
    end
  end

  // Three-digit item, advanced on each taken character
  always begin
    @(negedge core_clk);
    tk = (item_valid && item_ready) === 1'b1;
    @(posedge core_clk);
    #1;
    if (tk) begin
      idx++;
      item_data = 8'h31 + idx[7:0];
      item_last = idx == 2;
      if (idx == 3) begin
        item_valid = 1'b0;
        data_end = 1'b1;
      end
    end
  end

  // Main sequence
  initial begin
    void'($urandom(19703));
    repeat (3) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    run({S, "ARDAT K0", E}, 7'h00, {S, "A???? 0", E}, 1);
    run({S, "ARD", E}, 7'h00, {S, "A???? 0", E}, 0);
    // No verdict at all: the response deadline forces an unknown echo
    run({S, "ACTRL K0", E}, 7'h00, {S, "A???? 0", E}, 0);
    m.send({S, "ACTRL K0"}, 0);
    @(posedge core_clk);
    #1;
    run({S, "ACTRL K0", E}, 7'h60, {S, "ACTRL 0", E}, 1);
    bus_mode = 1'b1;
    run({S, "BCTRL K0", E}, 7'h00, "", 0);
    run({S, "ACTRL K0", E}, 7'h60, {S, "ACTRL 0", E}, 1);
    bus_mode = 1'b0;
    remote_mode = 1'b0;
    run({S, "ACTRL K0", E}, 7'h20, {S, "ACTRL 0 OF", E}, 1);
    system_unit = 1'b1;
    run({S, "AWRIT K0", E}, 7'h30, {S, "AWRIT 0 K0 OF", E}, 1);
    run({S, "AWRIT K12", E}, 7'h30, {S, "AWRIT 0 K12 OF", E}, 1);
    remote_mode = 1'b1;
    member_absent = 1'b1;
    run({S, "AWRIT K0", E}, 7'h30, {S, "AWRIT 0 K0 NA", E}, 1);
    member_absent = 1'b0;
    system_unit = 1'b0;
    func_running = 1'b1;
    run({S, "ACTRL K0", E}, 7'h20, {S, "ACTRL 0 BS", E}, 1);
    run({S, "AREST K0", E}, 7'h64, {S, "AREST 0", E}, 1);
    func_running = 1'b0;
    run({S, "ACTRL K0", E}, 7'h22, {S, "ACTRL 0 SE", E}, 1);
    run({S, "ACTRL K0", E}, 7'h21, {S, "ACTRL 0 DF", E}, 1);
    err_flags = 8'($urandom_range(127, 1));
    run({S, "AREAD K0", E}, 7'h28, {S, "AREAD 1", E}, 1);
    err_flags = err_flags | 8'h80;
    run({S, "AREAD K0", E}, 7'h28, {S, "AREAD 2", E}, 1);
    err_flags = 8'h00;
    run({S, "AREAD K0", E}, 7'h28, {S, "AREAD 0", E}, 1);
    // Random marks and lengths either side of the split limit
    repeat (6) begin
      {item_missing, item_limited} = 2'($urandom_range(3, 0));
      item_len = $urandom_range(1, 0) ? 8'h3D : 8'h3C;
      sep = " ";
      if (item_len == 8'h3D) sep = "\015\012";
      body = "123";
      if (item_limited) body = "#123";
      if (item_missing) body = "#";
      idx = 0;
      item_data = 8'h31;
      item_valid = 1'b1;
      data_end = 1'b0;
      run({S, "AREAD K0", E}, 7'h28, {S, "AREAD 0", sep, body, E}, 1);
    end
    give_verdict;
  end

  // Watchdog, about four times the expected run
  initial begin
    #250000;
    chk(1'b0, "watchdog");
    give_verdict;
  end
endmodule
